// File: core/reset_cause_and_interrupt_priority.sv
// Reset sequencer, reset cause register and interrupt arbiter.
// Assumes the CPU pulses its events on core_clk and obeys the outputs.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module reset_cause_and_interrupt_priority
    import reset_irq_pkg::*;
#(
    parameter int OSC_DELAY   = OSC_DELAY_FAST,  // Stabilisation delay.
    parameter int WDOG_LIMIT  = WDOG_BUS_CYCLES  // Watchdog period in bus cycles.
) (
    input  wire logic        core_clk,        // Fast clock, 100 MHz.
    input  wire logic        sys_rst,         // Power-on reset, active high.
    input  wire bus_req_s    bus_req,         // Register port request.
    output logic [7:0]       rdata,           // Read data, cycle after strobe.
    input  wire cpu_evt_s    cpu_evt,         // CPU event pulses.
    input  wire logic        global_mask,     // CPU global mask bit.
    input  wire periph_evt_s periph_evt,      // Peripheral event pulses.
    input  wire logic        lvi_low,         // Supply below trip, async.
    input  wire logic        rst_pin_in,      // Reset pin level, async.
    input  wire logic        irq_pin,         // Request pin, async.
    input  wire logic [6:0]  kbd_pin,         // Keyboard pins, async.
    input  wire logic        fault_pin,       // Fault input, async.
    input  wire logic        shutdown_input,  // Shutdown input, async.
    output logic             rst_pin_out,     // Reset pin drive value.
    output logic             rst_pin_oe_n,    // Reset pin enable, low drives.
    output logic             cpu_reset,       // Abort and hold the CPU.
    output logic             cpu_clock_hold,  // Keep CPU and module clocks off.
    output logic             vector_load,     // Pulse: load PC from vector.
    output logic [15:0]      vector_addr,     // Vector to fetch.
    output logic             int_take         // Pulse: stack and set mask.
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [11:0] sync1;    // First stage, read only by sync2.
    logic [11:0] sync2;    // Second stage.
    logic        fault_prev; // Fault level one cycle earlier.

    // Two flip-flops per asynchronous input; pins idle high, fault idles low.
    // The fault stage resets low so that no false rising edge follows reset.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1 <= 12'hff5;
            sync2 <= 12'hff5;
            fault_prev <= 1'b0;
        end else begin
            sync1 <= {kbd_pin, shutdown_input, fault_pin, irq_pin, lvi_low, rst_pin_in};
            sync2 <= sync1;
            fault_prev <= sync2[3];
        end
    end

    logic       rst_pin_s; // Reset pin.
    logic       lvi_s;     // Low supply.
    logic       irq_s;     // Request pin.
    logic       fault_s;   // Fault pin.
    logic       shut_s;    // Shutdown input.
    logic [6:0] kbd_s;     // Keyboard pins.
    assign rst_pin_s = sync2[0];
    assign lvi_s     = sync2[1];
    assign irq_s     = sync2[2];
    assign fault_s   = sync2[3];
    assign shut_s    = sync2[4];
    assign kbd_s     = sync2[11:5];

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0]         cause;    // Reset cause flags.
    logic [NUM_SRC-1:0] flags;    // Request flags.
    logic [NUM_SRC-1:0] enables;  // Local enables.
    logic [7:0]         config_word_one; // Configuration bits.
    rst_state_e         state;    // Reset sequencer state.
    rst_state_e         next_state;
    logic [12:0]        cnt;      // Delay counter.
    logic [12:0]        next_cnt;
    logic [1:0]         bus_div;  // Bus rate divider.
    logic [15:0]        wdog_cnt; // Watchdog counter.
    logic [2:0]         drive_hist; // Recent pin drive history.

    // Decoded accesses.
    logic wr_en, wr_flags, wr_flags2, wr_enable, wr_enable2, wr_cfg, wr_wdog;
    logic rd_cause;
    assign wr_en      = bus_req.wr;
    assign wr_flags   = wr_en && bus_req.addr == OFS_FLAGS;
    assign wr_flags2  = wr_en && bus_req.addr == OFS_FLAGS2;
    assign wr_enable  = wr_en && bus_req.addr == OFS_ENABLE;
    assign wr_enable2 = wr_en && bus_req.addr == OFS_ENABLE2;
    assign wr_cfg     = wr_en && bus_req.addr == OFS_CONFIG;
    assign wr_wdog    = wr_en && bus_req.addr == OFS_WDOG;
    assign rd_cause   = bus_req.rd && bus_req.addr == OFS_CAUSE;

    // ==========================================================
    // Reset causes
    // ==========================================================
    logic bus_en;     // One pulse every four fast cycles.
    logic wdog_ovf;   // Watchdog overflow.
    logic opc_bad;    // Illegal opcode or disabled stop.
    logic ext_low;    // External reset request.
    logic lvi_enter;  // Entering the low supply state.
    logic int_cause;  // Any internal reset source.
    logic running;    // CPU runs now.

    assign running   = state == ST_RUN;
    assign bus_en    = bus_div == 2'(FAST_PER_BUS - 1);
    assign wdog_ovf  = running && bus_en && wdog_cnt == 16'(WDOG_LIMIT - 1);
    assign opc_bad   = cpu_evt.bad_opcode
                       || (cpu_evt.stop_exec && !config_word_one[CFG_STOP_EN]);
    assign int_cause = wdog_ovf || opc_bad || cpu_evt.fetch_unmapped
                       || cpu_evt.monitor_entry;
    // Ignore the pin until our own drive has left the synchroniser.
    assign ext_low   = config_word_one[CFG_PIN_RESET] && !rst_pin_s
                       && drive_hist == 3'b000;
    assign lvi_enter = lvi_s && state != ST_LVI_LOW;

    // Next state of the reset sequencer.
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        if (lvi_enter) begin
            next_state = ST_LVI_LOW;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (int_cause) begin
                        next_state = ST_INT_RESET;
                        next_cnt   = 13'(INT_RESET_FAST - 1);
                    end else if (ext_low) begin
                        next_state = ST_EXT_RESET;
                    end
                end
                ST_POR_DELAY: begin
                    if (cnt == 13'h0000) begin
                        next_state = ST_POR_RELEASE;
                        next_cnt   = 13'(POR_RELEASE_FAST - 1);
                    end else begin
                        next_cnt = cnt - 13'h0001;
                    end
                end
                ST_LVI_LOW: begin
                    if (!lvi_s) begin
                        next_state = ST_LVI_DELAY;
                        next_cnt   = 13'(OSC_DELAY - 1);
                    end
                end
                ST_EXT_RESET: begin
                    if (rst_pin_s) next_state = ST_RUN;
                end
                ST_POR_RELEASE, ST_LVI_DELAY, ST_INT_RESET: begin
                    if (cnt == 13'h0000) next_state = ST_RUN;
                    else next_cnt = cnt - 13'h0001;
                end
            endcase
        end
    end

    // Sequencer state, from power-on into the stabilisation delay.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_POR_DELAY;
            cnt   <= 13'(OSC_DELAY - 1);
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Pin drive and CPU hold, registered from the next state.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_pin_out    <= 1'b0;
            rst_pin_oe_n   <= 1'b0;
            cpu_reset      <= 1'b1;
            cpu_clock_hold <= 1'b1;
            drive_hist     <= 3'b111;
        end else begin
            rst_pin_out    <= 1'b0;
            rst_pin_oe_n   <= !(config_word_one[CFG_PIN_RESET]
                              && next_state inside {ST_POR_DELAY, ST_POR_RELEASE,
                                 ST_LVI_LOW, ST_LVI_DELAY, ST_INT_RESET});
            cpu_reset      <= next_state != ST_RUN;
            cpu_clock_hold <= next_state inside {ST_POR_DELAY, ST_LVI_LOW,
                                                  ST_LVI_DELAY};
            drive_hist     <= {drive_hist[1:0], !rst_pin_oe_n};
        end
    end

    // Cause register: power-on leaves only its own flag.
    logic [7:0] cause_set; // Causes recorded this cycle.
    always_comb begin
        cause_set = 8'h00;
        cause_set[CAUSE_LVI]  = lvi_enter;
        if (!lvi_enter && running) begin
            cause_set[CAUSE_WDOG] = wdog_ovf;
            cause_set[CAUSE_OPC]  = opc_bad;
            cause_set[CAUSE_ADR]  = cpu_evt.fetch_unmapped;
            cause_set[CAUSE_MON]  = cpu_evt.monitor_entry;
            cause_set[CAUSE_PIN]  = !int_cause && ext_low;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cause <= CAUSE_POR_VALUE;
        end else begin
            cause <= (rd_cause ? 8'h00 : cause) | cause_set;
        end
    end

    // Bus rate divider and watchdog.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_div  <= 2'b00;
            wdog_cnt <= 16'h0000;
        end else begin
            bus_div <= bus_div + 2'b01;
            if (!running || wr_wdog) begin
                wdog_cnt <= 16'h0000;
            end else if (bus_en) begin
                wdog_cnt <= wdog_cnt + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Interrupt sources
    // ==========================================================
    logic [NUM_SRC-1:0] flag_set; // Events that set flags.
    logic [NUM_SRC-1:0] flag_clr; // Software clears, write one.
    logic [NUM_SRC-1:0] pending;  // Flag and enable.

    always_comb begin
        flag_set = '0;
        flag_set[SRC_EXT]  = config_word_one[CFG_IRQ_PIN] && !irq_s;
        flag_set[SRC_CH0]  = periph_evt.ch0;
        flag_set[SRC_CH1]  = periph_evt.ch1;
        flag_set[SRC_TOV]  = periph_evt.tovf;
        flag_set[SRC_FLT]  = fault_s && !fault_prev;
        flag_set[SRC_RLD]  = periph_evt.reload;
        flag_set[SRC_SHD]  = !shut_s;
        flag_set[SRC_KEY]  = kbd_s != 7'h7f;
        flag_set[SRC_CONV] = periph_evt.conv;
    end

    assign flag_clr = {wr_flags2 && bus_req.wdata[0],
                       wr_flags ? bus_req.wdata : 8'h00};
    assign pending  = flags & enables;

    // Flags hold until cleared; a set in the clearing cycle wins.
    always_ff @(posedge core_clk) begin
        if (sys_rst || cpu_reset) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // Local enables and configuration.
    always_ff @(posedge core_clk) begin
        if (sys_rst || cpu_reset) begin
            enables <= '0;
        end else begin
            if (wr_enable)  enables[7:0] <= bus_req.wdata;
            if (wr_enable2) enables[8]   <= bus_req.wdata[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) config_word_one <= CONFIG_RESET;
        else if (wr_cfg) config_word_one <= bus_req.wdata;
    end

    // ==========================================================
    // Arbiter and vector
    // ==========================================================
    logic reset_exit; // Sequencer returns to run.
    logic take_swi;   // Software interrupt entry.
    logic take_irq;   // Maskable entry.
    assign reset_exit = !running && next_state == ST_RUN;
    assign take_swi   = running && next_state == ST_RUN
                        && cpu_evt.instr_done && cpu_evt.swi_exec;
    assign take_irq   = running && next_state == ST_RUN && cpu_evt.instr_done
                        && !cpu_evt.swi_exec && !global_mask && |pending;

    // One entry decision per completed instruction, then latched.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vector_load <= 1'b0;
            vector_addr <= VEC_RESET;
            int_take    <= 1'b0;
        end else begin
            vector_load <= reset_exit || take_swi || take_irq;
            int_take    <= take_swi || take_irq;
            if (reset_exit) begin
                vector_addr <= VEC_RESET;
            end else if (take_swi) begin
                vector_addr <= VEC_SWI;
            end else if (take_irq) begin
                vector_addr <= vector_of(first_set(pending));
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_CAUSE:   rdata <= cause;
                OFS_FLAGS:   rdata <= flags[7:0];
                OFS_FLAGS2:  rdata <= {7'h00, flags[8] && !enables[8]};
                OFS_ENABLE:  rdata <= enables[7:0];
                OFS_ENABLE2: rdata <= {7'h00, enables[8]};
                OFS_CONFIG:  rdata <= config_word_one;
                default:     rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    int rel_len; // Cycles spent releasing after power-on.
    always_ff @(posedge core_clk) begin
        if (sys_rst || state != ST_POR_RELEASE) rel_len <= 0;
        else rel_len <= rel_len + 1;
    end

    sequence s_release_end;
        state == ST_POR_RELEASE ##1 state == ST_RUN;
    endsequence

    a_por_release_len: assert property (
        s_release_end |-> $past(rel_len) == POR_RELEASE_FAST - 1)
        else $error("power-on release length wrong");
    a_pin_low_release: assert property (
        state == ST_POR_RELEASE |-> !rst_pin_oe_n || !config_word_one[CFG_PIN_RESET])
        else $error("pin not driven in release");
    a_cause_read_clr: assert property (
        rd_cause && cause_set == 8'h00 |=> cause == 8'h00)
        else $error("cause not cleared by read");
    a_cause_sticky: assert property (
        !rd_cause |=> (cause & $past(cause)) == $past(cause))
        else $error("cause flag lost");
    a_wdog_reset: assert property (
        wdog_ovf && !lvi_enter |=> state == ST_INT_RESET && cause[CAUSE_WDOG])
        else $error("watchdog reset missed");
    a_wdog_restart: assert property (
        wr_wdog |=> wdog_cnt == 16'h0000)
        else $error("watchdog not restarted");
    a_swi_vector: assert property (
        take_swi |=> int_take && vector_addr == VEC_SWI)
        else $error("software interrupt not taken");
    a_mask_blocks: assert property (
        !cpu_evt.instr_done || (global_mask && !cpu_evt.swi_exec) |=> !int_take)
        else $error("masked entry taken");
    a_priority_pick: assert property (
        take_irq |=> vector_addr == vector_of(first_set($past(pending))))
        else $error("wrong priority vector");
    a_reset_vector: assert property (
        $fell(cpu_reset) |-> vector_load && vector_addr == VEC_RESET && !int_take)
        else $error("reset vector not loaded");
    a_ext_cause: assert property (
        running && ext_low && !int_cause && !lvi_enter |=> cause[CAUSE_PIN]
        && state == ST_EXT_RESET)
        else $error("external reset missed");
    a_flag_set_wins: assert property (
        !cpu_reset |=> (flags & $past(flag_set)) == $past(flag_set))
        else $error("flag set lost");

endmodule

// File: common/reset_irq_pkg.sv
// Constants, types and helpers shared by the reset and interrupt block.
// Assumes one fast clock and a CPU that pulses events on that clock.
package reset_irq_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [15:0] OFS_CAUSE   = 16'hfe01; // Reset cause, clear on read.
    localparam logic [15:0] OFS_FLAGS   = 16'hfe10; // Request flags 7..0.
    localparam logic [15:0] OFS_FLAGS2  = 16'hfe11; // Conversion flag in bit 0; reads zero while its enable is set.
    localparam logic [15:0] OFS_ENABLE  = 16'hfe12; // Local enables 7..0.
    localparam logic [15:0] OFS_ENABLE2 = 16'hfe13; // Converter enable in bit 0.
    localparam logic [15:0] OFS_CONFIG  = 16'hfe14; // Configuration bits.
    localparam logic [15:0] OFS_WDOG    = 16'hffff; // Watchdog restart.

    // Cause bit positions.
    localparam int CAUSE_POR  = 7;
    localparam int CAUSE_PIN  = 6;
    localparam int CAUSE_WDOG = 5;
    localparam int CAUSE_OPC  = 4;
    localparam int CAUSE_ADR  = 3;
    localparam int CAUSE_MON  = 2;
    localparam int CAUSE_LVI  = 1;
    localparam logic [7:0] CAUSE_POR_VALUE = 8'h80;

    // Request sources, index equals priority after the software interrupt.
    localparam int NUM_SRC  = 9;
    localparam int SRC_EXT  = 0;
    localparam int SRC_CH0  = 1;
    localparam int SRC_CH1  = 2;
    localparam int SRC_TOV  = 3;
    localparam int SRC_FLT  = 4;
    localparam int SRC_RLD  = 5;
    localparam int SRC_SHD  = 6;
    localparam int SRC_KEY  = 7;
    localparam int SRC_CONV = 8;

    // Configuration bits and reset value.
    localparam int CFG_STOP_EN   = 0;
    localparam int CFG_PIN_RESET = 1;
    localparam int CFG_IRQ_PIN   = 2;
    localparam logic [7:0] CONFIG_RESET = 8'h06;

    // Vectors.
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_SWI   = 16'hfffc;

    // Timing in fast clock cycles; the watchdog limit is in bus cycles.
    localparam int OSC_DELAY_FAST   = 4096;
    localparam int POR_RELEASE_FAST = 32;
    localparam int INT_RESET_FAST   = 32;
    localparam int FAST_PER_BUS     = 4;
    localparam int WDOG_BUS_CYCLES  = 8191;

    // Reset sequencer states.
    typedef enum logic [2:0] {
        ST_RUN, ST_POR_DELAY, ST_POR_RELEASE, ST_LVI_LOW,
        ST_LVI_DELAY, ST_INT_RESET, ST_EXT_RESET
    } rst_state_e;

    // Register port request.
    typedef struct packed {
        logic [15:0] addr;  // Byte address.
        logic [7:0]  wdata; // Write data.
        logic        wr;    // Write strobe.
        logic        rd;    // Read strobe.
    } bus_req_s;

    // CPU event pulses.
    typedef struct packed {
        logic instr_done;     // Current instruction completes.
        logic swi_exec;       // Software interrupt instruction completes.
        logic bad_opcode;     // Opcode outside the set.
        logic stop_exec;      // Stop instruction executed.
        logic fetch_unmapped; // Opcode fetch from unmapped address.
        logic monitor_entry;  // Forced monitor entry.
    } cpu_evt_s;

    // Peripheral event pulses.
    typedef struct packed {
        logic ch0;     // Timer channel 0 capture or compare.
        logic ch1;     // Timer channel 1 capture or compare.
        logic tovf;    // Timer rolled over after modulo match.
        logic reload;  // New reload cycle began.
        logic conv;    // Conversion complete.
    } periph_evt_s;

    // Vector address of a source index.
    function automatic logic [15:0] vector_of(input logic [3:0] idx);
        case (idx)
            4'h0:    return 16'hfffa;
            4'h1:    return 16'hfff6;
            4'h2:    return 16'hfff4;
            4'h3:    return 16'hfff2;
            4'h4:    return 16'hfff0;
            4'h5:    return 16'hffee;
            4'h6:    return 16'hffec;
            4'h7:    return 16'hffe0;
            default: return 16'hffde;
        endcase
    endfunction

    // Index of the highest-priority set bit.
    function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) r = 4'(i);
        end
        return r;
    endfunction

endpackage

// File: verification/cpu_model.sv
// CPU stand-in: retires instructions and keeps the global mask bit.
// Assumes the block's outputs on core_clk; returns are pulsed by the bench.
`timescale 1ns/10ps
module cpu_model (
    input  wire logic core_clk,    // Fast clock.
    input  wire logic cpu_reset,   // Hold from the block.
    input  wire logic int_take,    // Entry pulse.
    input  wire logic return_from_interrupt,         // Return pulse.
    output logic      instr_done,  // Instruction retired pulse.
    output logic      global_mask  // Global mask bit.
);
    // ==========================================================
    // Instruction timing and mask
    // ==========================================================
    logic [1:0] phase; // Cycles into the current instruction.
    // Every instruction takes four cycles.
    always_ff @(posedge core_clk) begin
        phase <= cpu_reset ? 2'h0 : phase + 2'h1;
        instr_done <= !cpu_reset && phase == 2'h3;
    end
    // Entry and reset set the mask; a return clears it.
    always_ff @(posedge core_clk) begin
        if (cpu_reset || int_take) global_mask <= 1'b1;
        else if (return_from_interrupt) global_mask <= 1'b0;
    end
endmodule

// File: verification/reset_cause_and_interrupt_priority_tb_top.sv
// Bench: random and corner stimulus for the reset and interrupt block.
// Assumes cpu_model plays the CPU; the reset pin has a pull-up.
`timescale 1ns/10ps
module reset_cause_and_interrupt_priority_tb_top
    import reset_irq_pkg::*;
;
    // ==========================================================
    // Signals and instances
    // ==========================================================
    logic core_clk, sys_rst, return_from_interrupt, software_interrupt, irq_pin, instr_done, global_mask, rst_pin_in;
    logic ext_n, low_voltage_flag, flt, shd, hold; // Pin stimulus and clock hold.
    logic [6:0] kbd;          // Keyboard pins.
    logic rst_pin_out, rst_pin_oe_n, cpu_reset, vector_load, int_take;
    logic [3:0] bad_ev;       // Opcode, stop, fetch and monitor events.
    logic [7:0] rdata;        // Register read data.
    logic [15:0] vector_addr; // Fetched vector.
    logic [31:0] seed = 32'hb475;
    logic [3:0] s;            // Chosen sources.
    int miscompares = 0, n_tests = 0, cycles = 0;
    bus_req_s bus_req;
    periph_evt_s periph_evt;
    // The pin floats high unless the block drives it or the bench pulls it low.
    assign rst_pin_in = (rst_pin_oe_n ? 1'b1 : rst_pin_out) & ext_n;
    reset_cause_and_interrupt_priority #(.OSC_DELAY(64), .WDOG_LIMIT(200)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
        .cpu_evt({instr_done, software_interrupt & instr_done, bad_ev}), .global_mask(global_mask),
        .periph_evt(periph_evt), .lvi_low(low_voltage_flag), .rst_pin_in(rst_pin_in),
        .irq_pin(irq_pin), .kbd_pin(kbd), .fault_pin(flt), .shutdown_input(shd),
        .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .cpu_reset(cpu_reset),
        .cpu_clock_hold(hold), .vector_load(vector_load), .vector_addr(vector_addr),
        .int_take(int_take));
    cpu_model cpu_u (.core_clk(core_clk), .cpu_reset(cpu_reset), .int_take(int_take),
        .return_from_interrupt(return_from_interrupt), .instr_done(instr_done), .global_mask(global_mask));
    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // The highest-priority source among those chosen wins.
    function automatic logic [15:0] pick(input logic [3:0] v);
        return v[3] ? 16'hfffa : v[0] ? 16'hfff6 : v[1] ? 16'hfff4 : 16'hfff2;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic take(input logic [15:0] exp);
        for (int i = 0; i < 300 && vector_load !== 1'b1; i++) @(posedge core_clk) #1;
        chk({15'h0, int_take}, {15'h0, exp != VEC_RESET});
        chk(vector_addr, exp);
    endtask
    // Return from the service routine, then expect the next entry.
    task automatic serve(input logic [15:0] exp);
        return_from_interrupt <= 1'b1;
        @(posedge core_clk);
        return_from_interrupt <= 1'b0;
        take(exp);
    endtask
    // A reset event holds the CPU, drives pin and clocks as expected, then restarts.
    // Bits of v: 5 low supply, 4 pin pulled low, 3..0 opcode, stop, fetch, monitor.
    task automatic fault(input logic [5:0] v, input logic [2:0] exp);
        @(posedge core_clk);
        {low_voltage_flag, ext_n, bad_ev} <= {v[5], !v[4], v[3:0]};
        @(posedge core_clk);
        bad_ev <= 4'h0;
        for (int i = 0; i < 1000 && cpu_reset !== 1'b1; i++) @(posedge core_clk) #1;
        chk({13'h0, cpu_reset, rst_pin_oe_n, hold}, {13'h0, exp});
        @(posedge core_clk);
        {low_voltage_flag, ext_n} <= 2'b01;
        for (int i = 0; i < 300 && cpu_reset !== 1'b0; i++) @(posedge core_clk) #1;
        chk(vector_addr, VEC_RESET);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // Clock, timeout and main sequence
    // ==========================================================
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // A hang is cut short well after the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        {sys_rst, return_from_interrupt, software_interrupt, irq_pin, ext_n, low_voltage_flag, flt, shd, kbd} = {8'h99, 7'h7f};
        {bad_ev, bus_req, periph_evt} = '0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        take(VEC_RESET);
        rdc(OFS_CAUSE, CAUSE_POR_VALUE);
        rdc(OFS_CAUSE, 8'h00);
        rdc(16'hfe30, 8'h00);
        wr(OFS_ENABLE, 8'hff);
        // Sources are raised while masked, so all are pending at entry.
        for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            s = seed[3:0] == 4'h0 ? 4'h4 : seed[3:0];
            wr(OFS_WDOG, seed[11:4]);
            periph_evt <= '{ch0: s[0], ch1: s[1], tovf: s[2], reload: 1'b0, conv: 1'b0};
            irq_pin <= !s[3];
            @(posedge core_clk);
            periph_evt <= '0;
            irq_pin <= 1'b1;
            repeat (6) @(posedge core_clk);
            serve(pick(s));
            wr(OFS_FLAGS, 8'hff);
        end
        software_interrupt <= 1'b1;
        take(VEC_SWI);
        software_interrupt <= 1'b0;
        // Fault edge, shutdown low and a key press arrive together while masked.
        @(posedge core_clk);
        {flt, shd, kbd} <= {2'b10, 7'h7e};
        @(posedge core_clk);
        {shd, kbd} <= {1'b1, 7'h7f};
        repeat (4) @(posedge core_clk);
        serve(16'hfff0);
        wr(OFS_FLAGS, 8'h10);
        serve(16'hffec);
        wr(OFS_FLAGS, 8'h40);
        serve(16'hffe0);
        wr(OFS_FLAGS, 8'hff);
        flt <= 1'b0;
        fault(6'h08, 3'h4);
        rdc(OFS_CAUSE, 8'h10);
        fault(6'h04, 3'h4);
        rdc(OFS_CAUSE, 8'h10);
        fault(6'h02, 3'h4);
        fault(6'h01, 3'h4);
        rdc(OFS_CAUSE, 8'h0c);
        fault(6'h00, 3'h4);
        rdc(OFS_CAUSE, 8'h20);
        fault(6'h10, 3'h6);
        rdc(OFS_CAUSE, 8'h40);
        fault(6'h20, 3'h5);
        rdc(OFS_CAUSE, 8'h02);
        results();
    end
endmodule
